// >>> core/sio_ctrl.sv
// Function
// - Level inhibit, true polarity: low pin zeroes output, enable stays On.
// - Unconnected inhibit pin reads high and has no effect at true polarity.
// - Level inhibit releases: output restored without operator action.
// - Inverted inhibit: high is the suppressing level.
// - Inhibit indicator set while suppressing, cleared when the inhibit releases.
// - Latched mode: valid pulse while On turns enable Off.
// - Pulses hold active level at least 30 us, both directions.
// - After latched shutdown output stays off until operator turns on.
// - Latched shutdown sets protection indicator until cleared; then turn-on allowed.
// - Latched mode: unconnected pin changes nothing.
// - Each pin has true or inverted polarity for all levels.
// - Output mode: logic 1 drives low, 0 high; inversion swaps.
// - Output mode may drive PWM from per-pin period and duty.
// - Input mode: sampled level readable after polarity.
// - Coupled on: operator Off-to-On emits one pulse.
// - Coupled on: received pulse while Off turns output On.
// - Coupled on: received pulse while On changes nothing.
// - Coupled on pin both receives and drives pulses.
// - Reset: coupled on true polarity, inhibit level true polarity.
// - Coupled off: operator On-to-Off emits one pulse.
// - Coupled off: received pulse while On turns output Off.
// - Coupled off: received pulse while Off changes nothing.
//
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
module sio_ctrl
  import sio_pkg::*;
(
  input wire logic aclk, // 25 MHz
  input wire logic aresetn, // Sync reset, active low
  input wire logic [ADDR_W-1:0] awaddr, // Write address
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Byte enables
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [ADDR_W-1:0] araddr, // Read address
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  input wire logic [NPIN-1:0] pin_in, // Pin levels seen
  output sio_pins_t pins, // Pin drive and enables
  output sio_stat_t stat // Enable, actual output, indicators
);

  sio_cfg_t cfg [NPIN];
  sio_pwm_t pwm [NPIN];
  logic [15:0] pwm_cnt [NPIN];
  logic [CW-1:0] act_cnt [NPIN];
  logic [CW-1:0] emit_cnt [NPIN];
  logic [NPIN-1:0] sync1, sync2, act, listen, pulse_ok;
  sio_out_t state, next_state;
  logic op_on, op_off, wr_fire, rd_fire, kill;
  logic cmd_on, cmd_off, cmd_clr;
  logic inh_lvl, inh_latch, son_md, soff_md, inh_hold;

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return a < A_TOP;
  endfunction

  // Word slot of an address within the map
  function automatic logic [2:0] slot(input logic [ADDR_W-1:0] a);
    return a[4:2];
  endfunction

  // Two flops per pin; reset to idle high like a floating pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= '1;
      sync2 <= '1;
    end else begin
      sync1 <= pin_in;
      sync2 <= sync1;
    end
  end

  // Active level per polarity; listening only in function modes and not while we drive
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      act[i] = ~(sync2[i] ^ cfg[i].inv);
      listen[i] = (cfg[i].mode == MD_FUNC || (i == PIN_INH && cfg[i].mode == MD_LATCH))
                  && emit_cnt[i] == '0;
      pulse_ok[i] = listen[i] && !act[i] && act_cnt[i] == PULSE_CYC;
    end
  end

  // Active-phase width counters, saturating at the minimum
  always_ff @(posedge aclk) begin
    for (int i = 0; i < NPIN; i++) begin
      if (!aresetn || !listen[i] || !act[i]) begin
        act_cnt[i] <= '0;
      end else if (act_cnt[i] != PULSE_CYC) begin
        act_cnt[i] <= act_cnt[i] + CW'(1);
      end
    end
  end

  assign inh_lvl = cfg[PIN_INH].mode == MD_FUNC;
  assign inh_latch = cfg[PIN_INH].mode == MD_LATCH;
  assign son_md = cfg[PIN_SON].mode == MD_FUNC;
  assign soff_md = cfg[PIN_SOFF].mode == MD_FUNC;
  assign inh_hold = inh_lvl && act[PIN_INH];
  // Idle pin never qualifies, so no shutdown without a real pulse
  assign kill = (inh_latch && pulse_ok[PIN_INH])
              || (soff_md && pulse_ok[PIN_SOFF]);

  // Write channel: both halves taken together in one cycle
  assign wr_fire = awready && awvalid && wvalid;
  // Full address match, so an unmapped write that aliases the command slot does nothing
  assign cmd_on = wr_fire && awaddr == A_CMD && wstrb[0] && wdata[CMD_ON];
  assign cmd_off = wr_fire && awaddr == A_CMD && wstrb[0] && wdata[CMD_OFF];
  assign cmd_clr = wr_fire && awaddr == A_CMD && wstrb[0] && wdata[CMD_CLR];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'h0;
      wready <= 1'h0;
      bvalid <= 1'h0;
      bresp <= RESP_OK;
    end else begin
      awready <= !awready && awvalid && wvalid && !bvalid;
      wready <= !awready && awvalid && wvalid && !bvalid;
      if (wr_fire) begin
        bvalid <= 1'h1;
        bresp <= mapped(awaddr) ? RESP_OK : RESP_ERR;
      end else if (bready) begin
        bvalid <= 1'h0;
      end
    end
  end

  // Configuration and PWM settings
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NPIN; i++) begin
        cfg[i] <= CFG_RST;
        pwm[i] <= PWM_RST;
      end
    end else if (wr_fire && mapped(awaddr)) begin
      for (int i = 0; i < NPIN; i++) begin
        if (slot(awaddr) == slot(A_CFG) + 3'(i)) begin
          cfg[i] <= CFG_W'(merge(32'(cfg[i]), wdata, wstrb));
        end
        if (slot(awaddr) == slot(A_PWM) + 3'(i)) begin
          pwm[i] <= merge(pwm[i], wdata, wstrb);
        end
      end
    end
  end

  // Read channel: one cycle to accept, one to answer
  assign rd_fire = arready && arvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'h0;
      rvalid <= 1'h0;
      rresp <= RESP_OK;
      rdata <= 32'h0;
    end else begin
      arready <= !arready && arvalid && !rvalid;
      if (rd_fire) begin
        rvalid <= 1'h1;
        rresp <= mapped(araddr) ? RESP_OK : RESP_ERR;
        rdata <= 32'h0;
        for (int i = 0; i < NPIN; i++) begin
          if (slot(araddr) == slot(A_CFG) + 3'(i)) begin
            rdata <= 32'(cfg[i]);
          end
          if (slot(araddr) == slot(A_PWM) + 3'(i)) begin
            rdata <= pwm[i];
          end
        end
        if (slot(araddr) == slot(A_STAT)) begin
          rdata <= {25'h0, act, stat};
        end
        // Unmapped reads must not alias a register slot
        if (!mapped(araddr)) begin
          rdata <= 32'h0;
        end
      end else if (rready) begin
        rvalid <= 1'h0;
      end
    end
  end

  // Output-enable state; operator off is checked first so its pulse still goes out
  always_comb begin
    next_state = state;
    op_on = 1'h0;
    op_off = 1'h0;
    case (state)
      OS_OFF: begin // Coupled off pulses not looked at while Off
        if (cmd_on && !stat.prot) begin
          next_state = OS_ON;
          op_on = 1'h1;
        end else if (son_md && pulse_ok[PIN_SON] && !stat.prot) begin
          next_state = OS_ON;
        end
      end
      OS_ON: begin // Coupled on pulses not looked at while On
        if (cmd_off) begin
          next_state = OS_OFF;
          op_off = 1'h1;
        end else if (kill) begin
          next_state = OS_OFF;
        end
      end
      default: begin
        next_state = OS_OFF;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= OS_OFF;
    end else begin
      state <= next_state;
    end
  end

  // Indicators; protection set wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat <= '{prot: 1'h0, inhibit_active_indicator: 1'h0, act: 1'h0, en: 1'h0};
    end else begin
      stat.en <= next_state == OS_ON;
      stat.act <= state == OS_ON && !inh_hold;
      stat.inhibit_active_indicator <= state == OS_ON && inh_hold;
      if (state == OS_ON && inh_latch && pulse_ok[PIN_INH]) begin
        stat.prot <= 1'h1;
      end else if (cmd_clr) begin
        stat.prot <= 1'h0;
      end
    end
  end

  // Outgoing pulse timers; only operator transitions emit, so coupled units never echo
  always_ff @(posedge aclk) begin
    for (int i = 0; i < NPIN; i++) begin
      if (!aresetn) begin
        emit_cnt[i] <= '0;
      end else if ((i == PIN_SON && op_on && son_md)
                   || (i == PIN_SOFF && op_off && soff_md)) begin
        emit_cnt[i] <= PULSE_CYC;
      end else if (emit_cnt[i] != '0) begin
        emit_cnt[i] <= emit_cnt[i] - CW'(1);
      end
    end
  end

  // PWM period counters
  always_ff @(posedge aclk) begin
    for (int i = 0; i < NPIN; i++) begin
      if (!aresetn || pwm[i].period == 16'h0 || pwm_cnt[i] >= pwm[i].period - 16'h1) begin
        pwm_cnt[i] <= 16'h0;
      end else begin
        pwm_cnt[i] <= pwm_cnt[i] + 16'h1;
      end
    end
  end

  // Pin drive; sync pins release the line when idle so the far end can pull it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins <= '{o: '0, oe: '0};
    end else begin
      for (int i = 0; i < NPIN; i++) begin
        case (cfg[i].mode)
          MD_OUT: begin
            pins.oe[i] <= 1'h1;
            pins.o[i] <= ~(cfg[i].val ^ cfg[i].inv);
          end
          MD_PWM: begin
            pins.oe[i] <= 1'h1;
            pins.o[i] <= ~((pwm_cnt[i] < pwm[i].duty) ^ cfg[i].inv);
          end
          MD_FUNC: begin
            pins.oe[i] <= i != PIN_INH && emit_cnt[i] != '0;
            pins.o[i] <= cfg[i].inv;
          end
          default: begin
            pins.oe[i] <= 1'h0;
            pins.o[i] <= 1'h0;
          end
        endcase
      end
    end
  end

  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic [CW:0] son_run;
  always_ff @(posedge aclk) begin
    if (!aresetn || !pins.oe[PIN_SON]) begin
      son_run <= '0;
    end else if (son_run[CW] == 1'h0) begin
      son_run <= son_run + (CW+1)'(1);
    end
  end

  property p_inh_zero;
    state == OS_ON && inh_lvl && act[PIN_INH] |=> !stat.act && stat.inhibit_active_indicator;
  endproperty
  a_inh_zero: assert property (p_inh_zero) else $error("inhibit did not zero output");

  property p_idle;
    state == OS_ON && sync2[PIN_INH] && !cfg[PIN_INH].inv |=> stat.act;
  endproperty
  a_idle: assert property (p_idle) else $error("idle inhibit pin blocked output");

  property p_restore;
    state == OS_ON && inh_lvl && !act[PIN_INH] |=> stat.act && !stat.inhibit_active_indicator;
  endproperty
  a_restore: assert property (p_restore) else $error("output not restored");

  property p_inv;
    state == OS_ON && inh_lvl && cfg[PIN_INH].inv && sync2[PIN_INH] |=> !stat.act;
  endproperty
  a_inv: assert property (p_inv) else $error("inverted inhibit ignored high");

  property p_ind;
    stat.act |-> !stat.inhibit_active_indicator;
  endproperty
  a_ind: assert property (p_ind) else $error("indicator with live output");

  property p_latch;
    state == OS_ON && inh_latch && pulse_ok[PIN_INH] |=> state == OS_OFF && stat.prot;
  endproperty
  a_latch: assert property (p_latch) else $error("latched shutdown missed");

  property p_width;
    $fell(pins.oe[PIN_SON]) && $past(cfg[PIN_SON].mode, 2) == MD_FUNC |-> $past(son_run) >= (CW+1)'(PULSE_CYC - 1);
  endproperty
  a_width: assert property (p_width) else $error("emitted pulse too short");

  property p_no_auto;
    stat.prot && state == OS_OFF |=> state == OS_OFF;
  endproperty
  a_no_auto: assert property (p_no_auto) else $error("turned on under protection");

  property p_prot;
    stat.prot && !cmd_clr |=> stat.prot;
  endproperty
  a_prot: assert property (p_prot) else $error("protection dropped");

  property p_son_emit;
    state == OS_OFF && cmd_on && !stat.prot && son_md |=> ##1 pins.oe[PIN_SON] [*3];
  endproperty
  a_son_emit: assert property (p_son_emit) else $error("no coupled on pulse");

  property p_son_in;
    state == OS_OFF && son_md && pulse_ok[PIN_SON] && !stat.prot |=> state == OS_ON;
  endproperty
  a_son_in: assert property (p_son_in) else $error("coupled on pulse ignored");

  property p_soff_in;
    state == OS_ON && soff_md && pulse_ok[PIN_SOFF] |=> state == OS_OFF ##1 !stat.en;
  endproperty
  a_soff_in: assert property (p_soff_in) else $error("coupled off pulse ignored");

  c_latch: cover property (state == OS_ON && inh_latch && pulse_ok[PIN_INH]);
  c_son: cover property (state == OS_OFF && son_md && pulse_ok[PIN_SON]);
  c_soff: cover property ($fell(pins.oe[PIN_SOFF]));
  c_inh: cover property (stat.inhibit_active_indicator ##1 stat.act);
endmodule

// >>> pkg/sio_pkg.sv
package sio_pkg;
  // Pin slots
  localparam int NPIN = 3;
  localparam int PIN_INH = 0;
  localparam int PIN_SON = 1;
  localparam int PIN_SOFF = 2;

  // Register map, one aligned word each
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] A_CMD = 8'h00;
  localparam logic [ADDR_W-1:0] A_CFG = 8'h04; // Pin i at A_CFG + 4*i
  localparam logic [ADDR_W-1:0] A_PWM = 8'h10; // Pin i at A_PWM + 4*i
  localparam logic [ADDR_W-1:0] A_STAT = 8'h1c;
  localparam logic [ADDR_W-1:0] A_TOP = 8'h20;

  // Command bits, write one to act
  localparam int CMD_ON = 0;
  localparam int CMD_OFF = 1;
  localparam int CMD_CLR = 2;

  // Pin modes
  localparam logic [2:0] MD_FUNC = 3'h0; // Level inhibit or coupled on/off
  localparam logic [2:0] MD_LATCH = 3'h1; // Latched shutdown, inhibit pin only
  localparam logic [2:0] MD_IN = 3'h2;
  localparam logic [2:0] MD_OUT = 3'h3;
  localparam logic [2:0] MD_PWM = 3'h4;

  typedef struct packed {
    logic val;
    logic inv;
    logic [2:0] mode;
  } sio_cfg_t;
  localparam int CFG_W = 5;
  localparam sio_cfg_t CFG_RST = '{val: 1'h0, inv: 1'h0, mode: MD_FUNC};

  typedef struct packed {
    logic [15:0] duty;
    logic [15:0] period;
  } sio_pwm_t;
  localparam sio_pwm_t PWM_RST = '{duty: 16'h0, period: 16'h0};

  typedef struct packed {
    logic [NPIN-1:0] o;
    logic [NPIN-1:0] oe;
  } sio_pins_t;

  typedef struct packed {
    logic prot;
    logic inhibit_active_indicator;
    logic act;
    logic en;
  } sio_stat_t;
  localparam int ST_IN_LSB = 4;

  // Pulse timing
  localparam int CLK_NS = 40;
  localparam int PULSE_MIN_NS = 30000;
  localparam int CW = 10;
  localparam logic [CW-1:0] PULSE_CYC = CW'((PULSE_MIN_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [1:0] {
    OS_OFF = 2'h1,
    OS_ON = 2'h2
  } sio_out_t;

  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
endpackage

// >>> test/sio_partner.sv
`timescale 1ns/100ps
module sio_partner
  import sio_pkg::*;
(
  input wire logic aclk, // System clock
  input sio_pins_t pins, // Device drive and enables
  output logic [NPIN-1:0] pin_in // Resolved wire levels
);
  logic [NPIN-1:0] ext_en = '0;
  logic [NPIN-1:0] ext_lvl = '1;

  // Wire level: device first, then instrument, else the pull-up
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      pin_in[i] = pins.oe[i] ? pins.o[i] : (ext_en[i] ? ext_lvl[i] : 1'b1);
    end
  end

  // Hold a level, or release the line to the pull-up
  task automatic drive(input int p, input logic en, input logic lvl);
    @(posedge aclk);
    ext_en[p] <= en;
    ext_lvl[p] <= lvl;
  endtask

  // Low pulse of n+1 cycles; shorter than 750 only when a test wants a refusal
  task automatic pulse(input int p, input int n);
    drive(p, 1'b1, 1'b0);
    repeat (n) @(posedge aclk);
    drive(p, 1'b0, 1'b1);
  endtask
endmodule

// >>> test/inhibit_and_sync_io_pins_tb.sv
`timescale 1ns/100ps
module inhibit_and_sync_io_pins_tb
  import sio_pkg::*;
();
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [NPIN-1:0] pin_in;
  sio_pins_t pins;
  sio_stat_t stat;
  logic [35:0] rq[$], bq[$], pq[$];
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int plen[NPIN];
  logic pmon = 1'b1;
  int unsigned duty, cnt;

  always #20 aclk = ~aclk;

  sio_ctrl dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .pin_in, .pins, .stat);
  sio_partner partner (.aclk, .pins, .pin_in);

  task automatic cmp(input string k, input logic [35:0] g, input logic [35:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: %s got %h expected %h", $time, k, g, e);
    end
  endtask

  task automatic conclude();
    fail_count += rq.size() + bq.size() + pq.size(); // Notes never answered
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic done(input string n);
    $display("Test %s finished", n);
  endtask

  // Expected note for one emitted pulse of the minimum width
  function automatic logic [35:0] pe(input int p);
    return {20'h0, 2'(p), 14'(30000 / 40)};
  endfunction

  // Write: address and data released each as taken, bready held until answered
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OK);
    bq.push_back({34'h0, r});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OK);
    rq.push_back({2'h0, r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Answers and emitted pulses taken against the oldest note
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready === 1'b1) cmp("read", {2'h0, rresp, rdata}, rq.size() ? rq.pop_front() : '1);
    if (bvalid === 1'b1 && bready === 1'b1) cmp("wresp", {34'h0, bresp}, bq.size() ? bq.pop_front() : '1);
    for (int i = 0; i < NPIN; i++) begin
      if (pins.oe[i] === 1'b1) plen[i] += (pins.o[i] === 1'b0) ? 1 : 1000; // Wrong level spoils the length
      else if (plen[i] != 0) begin
        if (pmon) cmp("pulse", {20'h0, 2'(i), 14'(plen[i])}, pq.size() ? pq.pop_front() : '1);
        plen[i] = 0;
      end
    end
  end

  // Watchdog well above the roughly 9k cycles the tests need
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      conclude();
    end
  end

  initial begin
    void'($urandom(40));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(A_STAT, 32'h0);
    for (int i = 0; i < NPIN; i++) begin
      rd(A_CFG + 8'(4 * i), 32'h0); // Function mode, true polarity
      rd(A_PWM + 8'(4 * i), 32'h0);
    end
    rd(A_TOP, 32'h0, RESP_ERR);
    wr(A_TOP, 32'h1, RESP_ERR);
    rd(A_STAT, 32'h0);
    done("reset");
    pq.push_back(pe(PIN_SON));
    wr(A_CMD, 32'h1);
    idle(800);
    rd(A_STAT, 32'h3);
    done("turn_on");
    partner.drive(PIN_INH, 1'b1, 1'b0);
    idle(10);
    rd(A_STAT, 32'h15); // Enable kept, output zero
    partner.drive(PIN_INH, 1'b0, 1'b1);
    idle(10);
    rd(A_STAT, 32'h3);
    wr(A_CFG, 32'h8);
    idle(10);
    rd(A_STAT, 32'h15); // Idle high now suppresses
    partner.drive(PIN_INH, 1'b1, 1'b0);
    idle(10);
    rd(A_STAT, 32'h3);
    partner.drive(PIN_INH, 1'b0, 1'b1);
    wr(A_CFG, 32'h0);
    done("level_inhibit");
    // Off, off again, short on, on, on again
    for (int k = 0; k < 5; k++) begin
      partner.pulse(k < 2 ? PIN_SOFF : PIN_SON, k == 2 ? 50 + $urandom % 690 : 760);
      idle(10);
      rd(A_STAT, k < 3 ? 32'h0 : 32'h3);
    end
    pq.push_back(pe(PIN_SOFF));
    wr(A_CMD, 32'h2);
    idle(800);
    rd(A_STAT, 32'h0);
    done("coupled");
    wr(A_CFG, 32'h1);
    pq.push_back(pe(PIN_SON));
    wr(A_CMD, 32'h1);
    idle(800);
    rd(A_STAT, 32'h3); // Idle pin harmless
    partner.pulse(PIN_INH, 760);
    idle(10);
    rd(A_STAT, 32'h8);
    wr(A_CMD, 32'h1);
    idle(800);
    rd(A_STAT, 32'h8); // Turn-on refused while latched
    wr(A_CMD, 32'h4);
    idle(10);
    rd(A_STAT, 32'h0); // Cleared but still off
    pq.push_back(pe(PIN_SON));
    wr(A_CMD, 32'h1);
    idle(800);
    rd(A_STAT, 32'h3);
    wr(A_CFG, 32'h0);
    done("latched");
    wr(A_CFG + 8'h8, 32'h2);
    partner.drive(PIN_SOFF, 1'b1, 1'b0);
    idle(10);
    rd(A_STAT, 32'h43);
    wr(A_CFG + 8'h8, 32'ha);
    idle(10);
    rd(A_STAT, 32'h3);
    partner.drive(PIN_SOFF, 1'b0, 1'b1);
    idle(10);
    wr(A_CFG + 8'h8, 32'h0);
    done("input");
    pmon = 1'b0;
    for (int k = 0; k < 4; k++) begin
      wr(A_CFG + 8'h4, {27'h0, k[1], k[0], MD_OUT});
      idle(3);
      cmp("pin", {34'h0, pins.oe[PIN_SON], pins.o[PIN_SON]}, {34'h0, 1'b1, k[1] == k[0]});
    end
    duty = 1 + $urandom % 9;
    wr(A_PWM + 8'h4, {16'(duty), 16'ha});
    wr(A_CFG + 8'h4, {27'h0, 2'h0, MD_PWM});
    idle(5);
    cnt = 0;
    repeat (100) begin
      @(posedge aclk);
      cnt += (pins.o[PIN_SON] === 1'b0);
    end
    cmp("pwm", 36'(cnt), 36'(duty * 10));
    wr(A_CFG + 8'h4, 32'h0);
    idle(5);
    pmon = 1'b1;
    done("output");
    conclude();
  end
endmodule
